/* File: core/pwmc_consts.svh */
// Purpose: Offsets, field positions, reset values and duty width of the modulator register block.
// Assumes: APB with 32-bit data; each register takes one aligned word.
// Notes: Definitions only.
`ifndef PWMC_CONSTS_SVH
`define PWMC_CONSTS_SVH

// Register byte offsets.
`define PWMC_OFS_CONTROL 12'h000
`define PWMC_OFS_DUTY_HIGH 12'h004
`define PWMC_OFS_DUTY_LOW 12'h008
`define PWMC_OFS_TIMEBASE 12'h00C

// Control register field positions.
`define PWMC_CTL_ON_BIT 7
`define PWMC_CTL_LEVEL_BIT 5
`define PWMC_CTL_INVERT_BIT 4

// Duty-low field position: the two low duty bits sit in bits 7:6.
`define PWMC_DCL_LSB 6

// Reset values.
`define PWMC_CTL_RESET 8'h00
`define PWMC_DUTY_POR 10'h000
`define PWMC_PRESCALE_RESET 8'h00

// Duty width in bits; the counter period follows from it as 1024 duty steps.
`define PWMC_DUTY_W 10

`endif

/* File: core/pwmc_pkg.sv */
// Purpose: Types shared by the modulator register block.
// Assumes: Included constants header gives the widths.
// Notes: Types only.
`include "pwmc_consts.svh"
package pwmc_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } pwmc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pwmc_apb_rsp_t;

  typedef struct packed {
    logic modulator_on;
    logic output_invert_select;
  } pwmc_ctl_t;

  typedef struct packed {
    logic [`PWMC_DUTY_W-1:0] cnt;
    logic tick;
    logic raw;
  } pwmc_eng_t;

  typedef struct packed {
    pwmc_apb_rsp_t rsp;
    pwmc_ctl_t ctl;
    logic [7:0] duty_high;
    logic [1:0] duty_low;
    logic [7:0] prescale;
    logic out;
  } pwmc_state_t;
endpackage

/* File: core/pwmc_engine.sv */
// Purpose: Duty comparison engine: free-running counter against the duty value, with prescaler enable.
// Assumes: Single clock pclk; advances only on step pulses.
// Notes: Raw output is active-high; polarity is applied by the parent.
`timescale 1ns/1ps
`default_nettype none
module pwmc_engine #(
  parameter int DUTY_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [7:0] prescale,
  input wire logic [DUTY_W-1:0] duty,
  output logic raw
);
  import pwmc_pkg::*;

  logic [7:0] div_q;
  logic [7:0] div_d;
  logic [DUTY_W-1:0] cnt_q;
  logic [DUTY_W-1:0] cnt_d;
  logic raw_q;
  logic raw_d;
  logic step;

  // Step pulse every prescale+1 cycles; counter and output clear to zero while stopped.
  always_comb begin
    step = run && (div_q == prescale);
    div_d = run ? (step ? 8'h00 : div_q + 8'h01) : 8'h00;
    cnt_d = !run ? '0 : (step ? cnt_q + 1'b1 : cnt_q);
    raw_d = run && (cnt_q < duty); // Output high for duty steps of each period.
  end

  // Engine registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
      cnt_q <= '0;
      raw_q <= 1'b0;
    end else begin
      div_q <= div_d;
      cnt_q <= cnt_d;
      raw_q <= raw_d;
    end
  end

  assign raw = raw_q;
endmodule
`default_nettype wire

/* File: core/pwmc_top.sv */
// Purpose: APB register block and output stage of one pulse-width modulator channel.
// Assumes: pclk at 100 MHz; presetn asynchronous active low for the control bits;
//          por_n marks a power-on or brown-out reset, any other reset keeps the duty value.
// Notes: Notes on behaviour follow.
`timescale 1ns/1ps
`default_nettype none
`include "pwmc_consts.svh"
module pwmc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pwm_out
);
  import pwmc_pkg::*;

  pwmc_state_t s_q;
  pwmc_state_t s_d;
  // Duty value lives apart from the reset-cleared state so that ordinary resets keep it.
  logic [7:0] duty_high_q;
  logic [7:0] duty_high_d;
  logic [1:0] duty_low_q;
  logic [1:0] duty_low_d;
  logic raw;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [31:0] rdata;

  // Access-phase write strobe and setup-phase read strobe; a write lands at the edge where the master samples pready high.
  // Read data is captured at the setup edge so that it already stands with pready.
  assign wr_en = psel && penable && pwrite && s_q.rsp.pready;
  assign rd_en = psel && !penable && !pwrite;

  pwmc_engine #(
    .DUTY_W(`PWMC_DUTY_W)
  ) u_engine (
    .pclk(pclk),
    .presetn(presetn),
    .run(s_q.ctl.modulator_on),
    .prescale(s_q.prescale),
    .duty({duty_high_q, duty_low_q}),
    .raw(raw)
  );

  // Read mux; unmapped addresses read zero and report an error.
  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      `PWMC_OFS_CONTROL: begin
        rdata[`PWMC_CTL_ON_BIT] = s_q.ctl.modulator_on;
        rdata[`PWMC_CTL_LEVEL_BIT] = s_q.out;
        rdata[`PWMC_CTL_INVERT_BIT] = s_q.ctl.output_invert_select;
      end
      `PWMC_OFS_DUTY_HIGH: begin
        rdata[7:0] = duty_high_q;
      end
      `PWMC_OFS_DUTY_LOW: begin
        rdata[7:`PWMC_DCL_LSB] = duty_low_q;
      end
      `PWMC_OFS_TIMEBASE: begin
        rdata[7:0] = s_q.prescale;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Next state of the control side and the bus answer.
  always_comb begin
    s_d = s_q;
    duty_high_d = duty_high_q;
    duty_low_d = duty_low_q;
    s_d.rsp.pready = psel && penable && !s_q.rsp.pready;
    s_d.rsp.pslverr = psel && penable && !s_q.rsp.pready && !hit;
    if (rd_en) begin
      s_d.rsp.prdata = rdata;
    end
    if (wr_en && pstrb[0]) begin
      case (paddr)
        `PWMC_OFS_CONTROL: begin
          s_d.ctl.modulator_on = pwdata[`PWMC_CTL_ON_BIT];
          s_d.ctl.output_invert_select = pwdata[`PWMC_CTL_INVERT_BIT];
        end
        `PWMC_OFS_DUTY_HIGH: begin
          duty_high_d = pwdata[7:0];
        end
        `PWMC_OFS_DUTY_LOW: begin
          duty_low_d = pwdata[7:`PWMC_DCL_LSB];
        end
        `PWMC_OFS_TIMEBASE: begin
          s_d.prescale = pwdata[7:0];
        end
        default: begin
        end
      endcase
    end
    // Polarity applies after the engine; a stopped channel shows its idle level.
    s_d.out = raw ^ s_q.ctl.output_invert_select;
    s_d.duty_high = duty_high_d;
    s_d.duty_low = duty_low_d;
  end

  // Control state clears on every presetn reset; por_n alone leaves it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.rsp <= '0;
      s_q.ctl <= '0;
      s_q.prescale <= `PWMC_PRESCALE_RESET;
      s_q.out <= 1'b0;
      s_q.duty_high <= 8'h00;
      s_q.duty_low <= 2'b00;
    end else begin
      s_q <= s_d;
    end
  end

  // Duty holds across ordinary resets; power-on clears it to a known pattern for simulation.
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      duty_high_q <= 8'h00;
      duty_low_q <= 2'b00;
    end else begin
      duty_high_q <= duty_high_d;
      duty_low_q <= duty_low_d;
    end
  end

  assign prdata = s_q.rsp.prdata;
  assign pready = s_q.rsp.pready;
  assign pslverr = s_q.rsp.pslverr;
  assign pwm_out = s_q.out;
endmodule
`default_nettype wire

/* File: sim/pwmc_top_checker.sv */
// Purpose: Port checker for the modulator register block.
// Assumes: A write lands at the edge where pready is sampled high.
// Notes: Shadows of the registers are rebuilt from bus traffic.
`timescale 1ns/1ps
`default_nettype none
module pwmc_top_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwm_out
);
  logic on_q, inv_q;
  logic [7:0] dh_q;
  logic [1:0] dl_q;
  logic wr, rd;
  // Only the low byte lane carries register data.
  assign wr = psel && penable && pwrite && pready && pstrb[0];
  assign rd = pready && !pwrite;
  // Control shadow follows the ordinary reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q <= 1'b0;
      inv_q <= 1'b0;
    end else if (wr && paddr == 12'h000) begin
      on_q <= pwdata[7];
      inv_q <= pwdata[4];
    end
  end
  // Duty shadow survives everything but power-on, so it has its own reset.
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      dh_q <= 8'h00;
      dl_q <= 2'h0;
    end else begin
      if (wr && paddr == 12'h004) dh_q <= pwdata[7:0];
      if (wr && paddr == 12'h008) dl_q <= pwdata[7:6];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  off_level_a: assert property ((!on_q && $stable(inv_q))[*4] |-> pwm_out == inv_q) else $error("idle level");
  duty_high_a: assert property (rd && paddr == 12'h004 |-> prdata == {24'h0, dh_q}) else $error("duty high");
  duty_low_a: assert property (rd && paddr == 12'h008 |-> prdata == {24'h0, dl_q, 6'h0}) else $error("duty low");
  ctl_read_a: assert property (rd && paddr == 12'h000 |-> prdata[31:6] == {24'h0, on_q, 1'b0})
    else $error("control read");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  ready_late_a: assert property (psel && $rose(penable) |=> pready) else $error("pready late");
  ready_only_a: assert property (pready |-> psel && penable) else $error("stray pready");
  bad_addr_a: assert property (rd && paddr > 12'h00C |-> pslverr && prdata == 32'h0) else $error("unmapped");
  cover property (wr && pwdata[7]);
  cover property (rd && paddr == 12'h008);
  cover property (pslverr);
endmodule
bind pwmc_top pwmc_top_checker chk (.pclk, .presetn, .por_n, .paddr, .psel, .penable, .pwrite, .pwdata,
  .pstrb, .prdata, .pready, .pslverr, .pwm_out);
`default_nettype wire

/* File: sim/tb_pwm_control_duty_regs.sv */
// Purpose: Self-checking bench for the modulator register block.
// Assumes: APB answers with one wait state.
// Notes: Duty values are random from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_control_duty_regs;
  logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, pwm_out, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  int err_total = 0, checks_done = 0, dh = 0, dl = 0;
  pwmc_top DUT (.pclk, .presetn, .por_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .pwm_out);
  // Free-running 100 MHz clock.
  initial forever #5 pclk = ~pclk;
  task end_sim;
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  // One APB transfer; it waits for pready as long as it takes, the watchdog ends a dead slave.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Watchdog, far beyond the few hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    end_sim;
  end
  // Main sequence.
  initial begin
    void'($urandom(91617));
    repeat (16) @(posedge pclk);
    {presetn, por_n} <= 2'h3;
    apb(0, 12'h000, 0); chk("ctl", 0, rd);
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      dh = v[7:0];
      dl = v[15:14];
      apb(1, 12'h004, v);
      apb(1, 12'h008, v >> 8);
      apb(0, 12'h004, 0); chk("dh", dh, rd);
      apb(0, 12'h008, 0); chk("dl", dl << 6, rd);
    end
    @(posedge pclk) presetn <= 0;
    @(posedge pclk) presetn <= 1;
    apb(0, 12'h004, 0); chk("keep", dh, rd);
    apb(1, 12'h000, 32'h10); repeat (4) @(posedge pclk); chk("inv", 1, pwm_out);
    apb(0, 12'h000, 0); chk("lvl", 32'h30, rd);
    apb(1, 12'h004, 32'hFF); apb(1, 12'h008, 32'hC0);
    apb(1, 12'h000, 32'h80); repeat (20) @(posedge pclk); chk("run", 1, pwm_out);
    apb(1, 12'h000, 32'h90); repeat (4) @(posedge pclk); chk("runinv", 0, pwm_out);
    apb(0, 12'h100, 0); chk("slverr", 1, er);
    @(posedge pclk) {presetn, por_n} <= 2'h0;
    @(posedge pclk) {presetn, por_n} <= 2'h3;
    apb(0, 12'h004, 0); chk("por", 0, rd);
    end_sim;
  end
endmodule
`default_nettype wire
